// [core/csb_top.sv]
// Content search memory: 32 entries of 32 bits with per-bit masking,
// encoded or two-beat unencoded match-vector result, classic Wishbone register slave.
// Assumes user logic on the same clock; IN_CE_I and OUT_CE_I stand in
// for the separate input-side and output-side clocks.
`timescale 1ns/100ps

module csb_top (
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic IN_CE_I,
    input wire logic OUT_CE_I,
    input wire logic WR_REQ_I,
    input wire logic [csb_pkg::CSB_AW-1:0] WR_ADDR_I,
    input wire logic [csb_pkg::CSB_W-1:0] WR_DATA_I,
    input wire logic [csb_pkg::CSB_W-1:0] WR_CARE_I,
    output logic WR_RDY_O,
    input wire logic SRCH_REQ_I,
    input wire logic [csb_pkg::CSB_W-1:0] SRCH_KEY_I,
    output logic SRCH_RDY_O,
    output logic HIT_O,
    output logic [csb_pkg::CSB_AW-1:0] HIT_ADDR_O,
    output logic [csb_pkg::CSB_LW-1:0] HIT_LINES_O,
    output logic HIT_HALF_O,
    output logic HIT_VALID_O,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic IRQ_O
);
    import csb_pkg::*;

    csb_st_t r;
    csb_st_t n;
    logic [CSB_N-1:0] mv_in;
    logic [CSB_N-1:0] mv_key;
    logic [CSB_N-1:0] self_vec;
    logic [CSB_IRQ_W-1:0] ev;
    logic in_opt;
    logic unenc;
    logic dout_opt;
    logic acc_w;
    logic acc_s;
    logic wb_req;
    logic rd_clr;
    logic self_hit;
    logic [CSB_LW-1:0] res_lo;
    logic [CSB_LW-1:0] res_hi;

    // Masked positions drop out of the compare; all entries in parallel
    function automatic logic [CSB_N-1:0] cam_match(
        input logic [CSB_W-1:0] k,
        input logic [CSB_N-1:0][CSB_W-1:0] d,
        input logic [CSB_N-1:0][CSB_W-1:0] c,
        input logic [CSB_N-1:0] v
    );
        logic [CSB_N-1:0] m;
        m = '0;
        for (int i = 0; i < CSB_N; i++) begin
            m[i] = v[i] & (((k ^ d[i]) & c[i]) == '0);
        end
        return m;
    endfunction

    // Lowest index wins; duplicates leave the others unreported
    function automatic logic [CSB_AW-1:0] enc_first(input logic [CSB_N-1:0] v);
        logic [CSB_AW-1:0] a;
        a = '0;
        for (int i = CSB_N - 1; i >= 0; i--) begin
            if (v[i]) begin
                a = CSB_AW'(i);
            end
        end
        return a;
    endfunction

    assign mv_in = cam_match(SRCH_KEY_I, r.data, r.care, r.valid);
    assign mv_key = cam_match(r.key, r.data, r.care, r.valid);
    assign self_vec = cam_match(r.wdata ^ ~r.wcare, r.data, r.care, r.valid);
    assign self_hit = self_vec[r.waddr];
    assign res_lo = r.res[CSB_LW-1:0];
    assign res_hi = r.res[CSB_N-1:CSB_LW];

    // Any read-side register option other than DOUT costs one extra input stage
    assign in_opt = r.ctrl[CSB_C_DIN_REG] | r.ctrl[CSB_C_RADR_REG] | r.ctrl[CSB_C_RSTB_REG];
    assign dout_opt = r.ctrl[CSB_C_DOUT_REG];
    assign unenc = r.ctrl[CSB_C_UNENC];
    assign acc_w = (r.st == CSB_IDLE) && IN_CE_I && WR_REQ_I;
    assign acc_s = (r.st == CSB_IDLE) && IN_CE_I && !WR_REQ_I && SRCH_REQ_I;
    assign wb_req = WB_CYC_I && WB_STB_I && !r.ack;
    assign rd_clr = wb_req && !WB_WE_I && (WB_ADR_I == CSB_ISTAT_OFS);

    always_comb begin
        n = r;
        n.hvld = 1'b0;
        n.ack = 1'b0;
        ev = '0;
        unique case (r.st)
            CSB_IDLE: begin
                if (acc_w) begin
                    // Write inputs always captured here, so WADR/WSTB cost nothing
                    n.waddr = WR_ADDR_I;
                    n.wdata = WR_DATA_I;
                    n.wcare = WR_CARE_I;
                    if (&WR_CARE_I) begin
                        n.wcnt = CSB_WR_CYC - 2'h1;
                    end else begin
                        n.wcnt = CSB_WR_CYC_MASKED - 2'h1;
                    end
                    n.st = CSB_WR;
                end else if (acc_s) begin
                    n.key = SRCH_KEY_I;
                    if (in_opt) begin
                        n.st = CSB_CMP;
                    end else begin
                        n.res = mv_in;
                        n.st = dout_opt ? CSB_HOLD : CSB_PRES;
                    end
                end
            end
            CSB_WR: begin
                if (IN_CE_I) begin
                    if (r.wcnt == 2'h1) begin
                        n.data[r.waddr] = r.wdata;
                        n.care[r.waddr] = r.wcare;
                        n.valid[r.waddr] = 1'b1;
                        ev[CSB_I_WDONE] = 1'b1;
                        n.st = CSB_IDLE;
                    end else begin
                        n.wcnt = r.wcnt - 2'h1;
                    end
                end
            end
            CSB_CMP: begin
                if (IN_CE_I) begin
                    n.res = mv_key;
                    n.st = dout_opt ? CSB_HOLD : CSB_PRES;
                end
            end
            CSB_HOLD: begin
                if (OUT_CE_I) begin
                    n.st = CSB_PRES;
                end
            end
            CSB_PRES: begin
                if (OUT_CE_I) begin
                    n.hit = |r.res;
                    n.multi = (r.res & (r.res - 32'h1)) != '0;
                    n.haddr = enc_first(r.res);
                    n.hvld = 1'b1;
                    // Encoded result is a first beat too, never a stale second
                    n.half = 1'b0;
                    ev[CSB_I_HIT] = |r.res;
                    ev[CSB_I_MISS] = ~|r.res;
                    if (unenc) begin
                        n.lines = res_lo;
                        n.st = CSB_HI;
                    end else begin
                        n.st = CSB_IDLE;
                    end
                end
            end
            CSB_HI: begin
                if (OUT_CE_I) begin
                    n.lines = res_hi;
                    n.half = 1'b1;
                    n.hvld = 1'b1;
                    n.st = CSB_IDLE;
                end
            end
        endcase

        // Register slave; unmapped reads return zero and still ack
        if (wb_req) begin
            n.ack = 1'b1;
            n.dat = '0;
            unique case (WB_ADR_I)
                CSB_CTRL_OFS: begin
                    n.dat[CSB_CTRL_W-1:0] = r.ctrl;
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        n.ctrl = WB_DAT_I[CSB_CTRL_W-1:0];
                    end
                end
                CSB_STAT_OFS: begin
                    n.dat[CSB_S_WBUSY] = (r.st == CSB_WR);
                    n.dat[CSB_S_SBUSY] = (r.st != CSB_WR) && (r.st != CSB_IDLE);
                    n.dat[CSB_S_HIT] = r.hit;
                    n.dat[CSB_S_MULTI] = r.multi;
                    n.dat[CSB_S_ADDR_LSB +: CSB_AW] = r.haddr;
                end
                CSB_ISTAT_OFS: begin
                    n.dat[CSB_IRQ_W-1:0] = r.ist;
                end
                CSB_IMASK_OFS: begin
                    n.dat[CSB_IRQ_W-1:0] = r.imsk;
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        n.imsk = WB_DAT_I[CSB_IRQ_W-1:0];
                    end
                end
                default: begin
                    n.dat = '0;
                end
            endcase
        end
        // A fresh event outlives a read-clear in the same cycle
        n.ist = (r.ist & ~{CSB_IRQ_W{rd_clr}}) | ev;
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            r <= '0;
            r.st <= CSB_IDLE;
            r.ctrl <= CSB_CTRL_RST;
            r.imsk <= CSB_IMASK_RST;
            r.data <= CSB_INIT_DATA;
            r.care <= CSB_INIT_CARE;
            r.valid <= CSB_INIT_VALID;
        end else begin
            r <= n;
        end
    end

    // Write wins a tie so a search never sees a half-written entry
    assign WR_RDY_O = (r.st == CSB_IDLE);
    assign SRCH_RDY_O = (r.st == CSB_IDLE) && !WR_REQ_I;
    assign HIT_O = r.hit;
    assign HIT_ADDR_O = r.haddr;
    assign HIT_LINES_O = r.lines;
    assign HIT_HALF_O = r.half;
    assign HIT_VALID_O = r.hvld;
    assign WB_DAT_O = r.dat;
    assign WB_ACK_O = r.ack;
    assign IRQ_O = |(r.ist & r.imsk);

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_B_I);

    search_lat_a: assert property (
        (acc_s && !in_opt && !dout_opt) ##1 OUT_CE_I |=> HIT_VALID_O && !HIT_HALF_O)
        else $error("search result not presented on time");

    hit_flag_a: assert property (
        (r.st == CSB_PRES && OUT_CE_I && |r.res) |=> HIT_O && HIT_VALID_O)
        else $error("hit flag missing on a match");

    miss_flag_a: assert property (
        (r.st == CSB_PRES && OUT_CE_I && !(|r.res)) |=> !HIT_O && HIT_VALID_O)
        else $error("hit flag raised without a match");

    mask_hit_a: assert property (
        (r.st == CSB_WR && IN_CE_I && r.wcnt == 2'h1) |=> self_hit)
        else $error("masked bits blocked a match");

    enc_addr_a: assert property (
        (r.st == CSB_PRES && OUT_CE_I && !unenc && |r.res)
        |=> HIT_ADDR_O == enc_first($past(r.res)))
        else $error("encoded address wrong");

    hi_beat_a: assert property (
        (r.st == CSB_HI && OUT_CE_I)
        |=> HIT_HALF_O && HIT_VALID_O && HIT_LINES_O == $past(res_hi))
        else $error("second beat lines wrong");

    lo_beat_a: assert property (
        (r.st == CSB_PRES && OUT_CE_I && unenc)
        |=> !HIT_HALF_O && HIT_LINES_O == $past(res_lo))
        else $error("first beat lines wrong");

    two_beats_a: assert property (
        (r.st == CSB_PRES && OUT_CE_I && unenc) ##1 OUT_CE_I |=> HIT_VALID_O && HIT_HALF_O)
        else $error("second beat not given");

    wr_plain_a: assert property (
        (acc_w && &WR_CARE_I) ##1 IN_CE_I |=> r.st == CSB_IDLE && WR_RDY_O)
        else $error("plain write not two cycles");

    wr_masked_a: assert property (
        (acc_w && !(&WR_CARE_I)) ##1 IN_CE_I |=> r.st == CSB_WR && !WR_RDY_O)
        else $error("masked write ended too early");

endmodule

// [core/csb_pkg.sv]
// Constants, register map and state types of the content search block.
// Assumes a single 125 MHz core clock shared by user logic and the bus.
package csb_pkg;

    localparam int CSB_N = 32;
    localparam int CSB_W = 32;
    localparam int CSB_AW = 5;
    localparam int CSB_LW = 16;

    localparam logic [1:0] CSB_WR_CYC = 2'h2;
    localparam logic [1:0] CSB_WR_CYC_MASKED = 2'h3;

    localparam logic [7:0] CSB_CTRL_OFS = 8'h00;
    localparam logic [7:0] CSB_STAT_OFS = 8'h04;
    localparam logic [7:0] CSB_ISTAT_OFS = 8'h08;
    localparam logic [7:0] CSB_IMASK_OFS = 8'h0C;

    localparam int CSB_C_UNENC = 0;
    localparam int CSB_C_DIN_REG = 1;
    localparam int CSB_C_DOUT_REG = 2;
    localparam int CSB_C_RADR_REG = 3;
    localparam int CSB_C_WADR_REG = 4;
    localparam int CSB_C_WSTB_REG = 5;
    localparam int CSB_C_RSTB_REG = 6;
    localparam int CSB_CTRL_W = 7;
    localparam logic [CSB_CTRL_W-1:0] CSB_CTRL_RST = 7'h00;

    localparam int CSB_S_WBUSY = 0;
    localparam int CSB_S_SBUSY = 1;
    localparam int CSB_S_HIT = 2;
    localparam int CSB_S_MULTI = 3;
    localparam int CSB_S_ADDR_LSB = 8;

    localparam int CSB_I_HIT = 0;
    localparam int CSB_I_MISS = 1;
    localparam int CSB_I_WDONE = 2;
    localparam int CSB_IRQ_W = 3;
    localparam logic [CSB_IRQ_W-1:0] CSB_IMASK_RST = 3'h0;

    // Contents present straight after reset
    localparam logic [CSB_N-1:0][CSB_W-1:0] CSB_INIT_DATA = '0;
    localparam logic [CSB_N-1:0][CSB_W-1:0] CSB_INIT_CARE = '1;
    localparam logic [CSB_N-1:0] CSB_INIT_VALID = 32'h0;

    typedef enum logic [2:0] {
        CSB_IDLE,
        CSB_WR,
        CSB_CMP,
        CSB_HOLD,
        CSB_PRES,
        CSB_HI
    } csb_phase_t;

    typedef struct packed {
        csb_phase_t st;
        logic [CSB_CTRL_W-1:0] ctrl;
        logic [CSB_IRQ_W-1:0] ist;
        logic [CSB_IRQ_W-1:0] imsk;
        logic [CSB_N-1:0][CSB_W-1:0] data;
        logic [CSB_N-1:0][CSB_W-1:0] care;
        logic [CSB_N-1:0] valid;
        logic [1:0] wcnt;
        logic [CSB_AW-1:0] waddr;
        logic [CSB_W-1:0] wdata;
        logic [CSB_W-1:0] wcare;
        logic [CSB_W-1:0] key;
        logic [CSB_N-1:0] res;
        logic hit;
        logic multi;
        logic [CSB_AW-1:0] haddr;
        logic [CSB_LW-1:0] lines;
        logic hvld;
        logic half;
        logic ack;
        logic [31:0] dat;
    } csb_st_t;

endpackage

// [bench/csb_user_model.sv]
// User logic model beside the search block: writes entries, issues searches.
// Assumes the shared core clock; requests launch right after a rising edge.
`timescale 1ns/100ps

module csb_user_model (
    input wire logic clk_i,
    input wire logic wr_rdy_i,
    input wire logic srch_rdy_i,
    output logic wr_req_o,
    output logic [csb_pkg::CSB_AW-1:0] wr_addr_o,
    output logic [csb_pkg::CSB_W-1:0] wr_data_o,
    output logic [csb_pkg::CSB_W-1:0] wr_care_o,
    output logic srch_req_o,
    output logic [csb_pkg::CSB_W-1:0] srch_key_o
);
    import csb_pkg::*;

    initial begin
        wr_req_o = 1'b0;
        wr_addr_o = 5'h00;
        wr_data_o = 32'h0;
        wr_care_o = 32'hFFFFFFFF;
        srch_req_o = 1'b0;
        srch_key_o = 32'h0;
    end

    // Held until taken; released lines scrambled so stale data never matches
    task automatic wr(input logic [CSB_AW-1:0] a, input logic [CSB_W-1:0] d,
                      input logic [CSB_W-1:0] c);
        @(posedge clk_i);
        wr_req_o <= 1'b1;
        wr_addr_o <= a;
        wr_data_o <= d;
        wr_care_o <= c;
        do @(posedge clk_i); while (wr_rdy_i !== 1'b1);
        wr_req_o <= 1'b0;
        wr_addr_o <= ~a;
        wr_data_o <= ~d;
        wr_care_o <= ~c;
    endtask

    task automatic srch(input logic [CSB_W-1:0] k);
        @(posedge clk_i);
        srch_req_o <= 1'b1;
        srch_key_o <= k;
        do @(posedge clk_i); while (srch_rdy_i !== 1'b1);
        srch_req_o <= 1'b0;
        srch_key_o <= ~k;
    endtask
endmodule

// [bench/test_csb_top.sv]
// Self-checking bench of the content search block.
// Drives both clock enables; user logic comes from the partner model.
`timescale 1ns/100ps

module test_csb_top;
    import csb_pkg::*;

    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr_req, wr_rdy, srch_req, srch_rdy, hit, hit_half, hit_vld;
    logic [CSB_AW-1:0] wr_addr, hit_addr;
    logic [CSB_W-1:0] wr_data, wr_care, srch_key;
    logic [CSB_LW-1:0] hit_lines;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'h0;
    logic in_ce = 1'b1;
    logic out_ce = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, q;
    logic ack, irq;
    int errors = 0;
    int checked = 0;
    int cyc_n = 0;

    always #4 core_clk = ~core_clk;

    csb_user_model U (.clk_i(core_clk), .wr_rdy_i(wr_rdy), .srch_rdy_i(srch_rdy),
        .wr_req_o(wr_req), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .wr_care_o(wr_care),
        .srch_req_o(srch_req), .srch_key_o(srch_key));

    csb_top DUT (.CORE_CLK_I(core_clk), .RST_B_I(rst_b), .IN_CE_I(in_ce), .OUT_CE_I(out_ce),
        .WR_REQ_I(wr_req), .WR_ADDR_I(wr_addr), .WR_DATA_I(wr_data), .WR_CARE_I(wr_care),
        .WR_RDY_O(wr_rdy), .SRCH_REQ_I(srch_req), .SRCH_KEY_I(srch_key),
        .SRCH_RDY_O(srch_rdy), .HIT_O(hit), .HIT_ADDR_O(hit_addr), .HIT_LINES_O(hit_lines),
        .HIT_HALF_O(hit_half), .HIT_VALID_O(hit_vld), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .IRQ_O(irq));

    task automatic report_and_stop();
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 5000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            errors++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask

    // Classic single cycle, released only after the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= a;
        wdat <= d;
        do @(posedge core_clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask

    // Busy cycles after acceptance: one plain, two with masked bits
    task automatic wr_chk(input logic [4:0] a, input logic [31:0] d, input logic [31:0] c);
        int n;
        int e;
        n = 0;
        e = (c == 32'hFFFFFFFF) ? CSB_WR_CYC - 1 : CSB_WR_CYC_MASKED - 1;
        U.wr(a, d, c);
        @(posedge core_clk);
        while (wr_rdy !== 1'b1 && n < 10) begin
            n++;
            @(posedge core_clk);
        end
        chk(n == e, "write time");
    endtask

    task automatic srch_chk(input logic [31:0] k, input logic h, input logic [4:0] a);
        U.srch(k);
        do @(posedge core_clk); while (hit_vld !== 1'b1);
        chk(hit === h && (h === 1'b0 || hit_addr === a), "search result");
    endtask

    // Read-path registers add two stages; each side waits for its own enable
    task automatic opt_chk();
        int n;
        n = 0;
        wb(1'b1, CSB_CTRL_OFS, 32'h06);
        U.srch(32'h123456AB);
        while (hit_vld !== 1'b1 && n < 20) begin
            n++;
            @(posedge core_clk);
        end
        chk(n == 4 && hit === 1'b1 && hit_addr === 5'h14, "option latency");
        out_ce <= 1'b0;
        U.srch(32'hA5A50001);
        in_ce <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk(hit_vld === 1'b0 && srch_rdy === 1'b0, "input side stalled");
        in_ce <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(hit_vld === 1'b0 && srch_rdy === 1'b0, "output side stalled");
        out_ce <= 1'b1;
        do @(posedge core_clk); while (hit_vld !== 1'b1);
        chk(hit === 1'b1 && hit_addr === 5'h03, "stalled search result");
    endtask

    task automatic unenc_chk();
        U.srch(32'hA5A50001);
        do @(posedge core_clk); while (hit_vld !== 1'b1);
        chk(hit_half === 1'b0 && hit_lines === 16'h0088, "first beat");
        @(posedge core_clk);
        chk(hit_vld === 1'b1 && hit_half === 1'b1 && hit_lines === 16'h0002, "second beat");
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        wb(1'b0, CSB_CTRL_OFS, 32'h0);
        chk(q === 32'h0, "ctrl reset");
        wb(1'b1, CSB_IMASK_OFS, 32'h1);
        wr_chk(5'h03, 32'hA5A50001, 32'hFFFFFFFF);
        wr_chk(5'h14, 32'h12345600, 32'hFFFFFF00);
        srch_chk(32'h0, 1'b0, 5'h00);
        chk(irq === 1'b0, "masked miss irq");
        srch_chk(32'hA5A50001, 1'b1, 5'h03);
        srch_chk(32'h123456FF, 1'b1, 5'h14);
        chk(irq === 1'b1, "hit irq");
        wb(1'b0, CSB_ISTAT_OFS, 32'h0);
        chk(q === 32'h7, "int status");
        @(posedge core_clk);
        chk(irq === 1'b0, "irq cleared");
        wb(1'b0, 8'h10, 32'h0);
        chk(q === 32'h0, "unmapped read");
        wb(1'b1, CSB_CTRL_OFS, 32'h7F);
        wb(1'b0, CSB_CTRL_OFS, 32'h0);
        chk(q === 32'h7F, "ctrl options");
        opt_chk();
        wb(1'b1, CSB_CTRL_OFS, 32'h1);
        // Duplicates only once unencoded output is chosen
        wr_chk(5'h07, 32'hA5A50001, 32'hFFFFFFFF);
        wr_chk(5'h11, 32'hA5A50001, 32'hFFFFFFFF);
        unenc_chk();
        // Hit, multiple hits, lowest matching entry 3
        wb(1'b0, CSB_STAT_OFS, 32'h0);
        chk(q === 32'h0000030C, "status after duplicates");
        // Reset mid-run brings back the preload: no valid entry left
        rst_b <= 1'b0;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        srch_chk(32'hA5A50001, 1'b0, 5'h00);
        report_and_stop();
    end
endmodule
